//--- src/ibc_bus_cond.sv
/*
 * Bus condition front end of a two-wire serial port, device side.
 * Pins are sampled on the link clock, carried into the system clock domain,
 * and Start, Stop, Restart, collision and addressing are decided there.
 * Assumes open-drain pads outside: a low output enable pulls the wire low.
 */
// Contract
// - Enabled I2C mode: both lines open-drain only.
// - Pin output data fixed at zero when enabled.
// - Long hold select picks SDA hold time.
// - Idle only when unowned and both high.
// - Address matches only a match value.
// - Collision: SDA low while releasing high.
// - SDA fall with SCL high is Start.
// - Start generation collides if SDA already low.
// - SDA rise with SCL high is Stop.
// - Stop needs an SCL low period first.
// - Restart valid whenever Stop would be.
// - Restart resets transfer logic like Start.
// - Addressed 10-bit read holds SCL low.
// - Prior match flag set and cleared correctly.
// - First 10-bit byte compared with header pattern.
`timescale 1ns/1ps
`default_nettype none

module ibc_bus_cond
    import ibc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic link_clk_i,
    input wire logic scl_pin_i,
    input wire logic sda_pin_i,
    output logic scl_o,
    output logic scl_oe_n_o,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic serial_port_enable_i,
    input wire logic i2c_mode_sel_i,
    input wire logic ten_bit_mode_i,
    input wire logic long_hold_select_i,
    input wire logic [7:0] slave_address_match_value_i,
    input wire logic [7:0] slave_address_match_value_two_i,
    input wire logic [9:0] ten_bit_address_i,
    input wire logic start_gen_req_i,
    input wire logic tx_enable_i,
    input wire logic tx_bit_i,
    input wire logic read_release_i,
    output logic bus_idle_o,
    output logic start_det_o,
    output logic stop_det_o,
    output logic restart_det_o,
    output logic collision_o,
    output logic addr_match_o,
    output logic prior_match_o,
    output logic read_hold_o
);

    // ------------------------------------------------------------
    // Pin sampling and domain crossing
    // ------------------------------------------------------------
    logic [1:0] link_lvl;
    logic [1:0] sys_lvl;

    ibc_sync #(.WIDTH(2)) u_link_sync (
        .clk_i(link_clk_i),
        .reset_n_i(reset_n_i),
        .d_i({scl_pin_i, sda_pin_i}),
        .q_o(link_lvl)
    );

    ibc_sync #(.WIDTH(2)) u_sys_sync (
        .clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .d_i(link_lvl),
        .q_o(sys_lvl)
    );

    wire scl_s = sys_lvl[1];
    wire sda_s = sys_lvl[0];

    // ------------------------------------------------------------
    // Condition decode
    // ------------------------------------------------------------
    logic scl_p;
    logic sda_p;
    logic bus_active;
    logic scl_low_seen;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    ibc_addr_t addr_st;
    logic read_pend;
    logic read_hold;
    logic gen_drive;
    logic [3:0] hold_cnt;
    logic sda_tx;

    wire en = serial_port_enable_i & i2c_mode_sel_i;
    wire scl_high = scl_s & scl_p;
    wire sda_fall = sda_p & ~sda_s & scl_high;
    wire sda_rise = ~sda_p & sda_s & scl_high;
    wire scl_rise = ~scl_p & scl_s;
    wire scl_fall = scl_p & ~scl_s;
    wire start_w = en & sda_fall & ~bus_active;
    wire restart_w = en & sda_fall & bus_active & scl_low_seen;
    wire stop_w = en & sda_rise & bus_active & scl_low_seen;
    wire frame_reset = start_w | restart_w;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire byte_done = en & bus_active & scl_rise & (bit_cnt == BITS_PER_BYTE - 4'h1);
    wire [7:0] rx_byte = {shift[6:0], sda_s};
    wire rx_read = rx_byte[RW_BIT];
    // The direction bit is left out of the 7-bit compare.
    wire match7 = (rx_byte[7:1] == slave_address_match_value_i[7:1])
                | (rx_byte[7:1] == slave_address_match_value_two_i[7:1]);
    wire hi_match = (rx_byte[HDR_MSB:HDR_LSB] == TEN_BIT_HEADER)
                  & (rx_byte[HI_ADDR_MSB:HI_ADDR_LSB] == ten_bit_address_i[9:8]);
    wire lo_match = rx_byte == ten_bit_address_i[7:0];
    wire first_byte = byte_done & (addr_st == ADDR_FIRST);
    wire ten_first = first_byte & ten_bit_mode_i;
    // A read header only counts after a full write match.
    wire ten_read_ok = ten_first & hi_match & rx_read & prior_match_o;
    wire full_match = (first_byte & ~ten_bit_mode_i & match7)
                    | (byte_done & (addr_st == ADDR_LOW) & lo_match)
                    | ten_read_ok;
    wire prior_clear = stop_w | (ten_first & (~hi_match | ~rx_read));
    wire prior_set = byte_done & (addr_st == ADDR_LOW) & lo_match;

    ibc_addr_t next_addr_st;
    always_comb
    begin
        next_addr_st = addr_st;
        if (!en || frame_reset || stop_w)
        begin
            next_addr_st = ADDR_FIRST;
        end
        else if (byte_done)
        begin
            unique case (addr_st)
                ADDR_FIRST:
                begin
                    if (ten_bit_mode_i)
                    begin
                        if (hi_match && !rx_read)
                            next_addr_st = ADDR_LOW;
                        else if (ten_read_ok)
                            next_addr_st = ADDR_DATA;
                        else
                            next_addr_st = ADDR_IGNORE;
                    end
                    else
                    begin
                        next_addr_st = match7 ? ADDR_DATA : ADDR_IGNORE;
                    end
                end
                ADDR_LOW: next_addr_st = lo_match ? ADDR_DATA : ADDR_IGNORE;
                ADDR_DATA: next_addr_st = ADDR_DATA;
                ADDR_IGNORE: next_addr_st = ADDR_IGNORE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Transmit hold and collision decode
    // ------------------------------------------------------------
    wire [3:0] hold_load = long_hold_select_i ? HOLD_LONG_CNT : HOLD_SHORT_CNT;
    wire hold_busy = hold_cnt != 4'h0;
    wire tx_collide = en & tx_enable_i & sda_tx & scl_rise & ~sda_s;
    wire gen_ok = en & start_gen_req_i & ~bus_active & scl_s;
    wire gen_collide = gen_ok & ~sda_s;
    wire drive_sda = en & (gen_drive | (tx_enable_i & ~sda_tx));

    // ------------------------------------------------------------
    // Bus state registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            scl_p <= 1'b1;
            sda_p <= 1'b1;
            bus_active <= 1'b0;
            scl_low_seen <= 1'b0;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            addr_st <= ADDR_FIRST;
        end
        else
        begin
            scl_p <= scl_s;
            sda_p <= sda_s;
            addr_st <= next_addr_st;
            if (!en || stop_w)
                bus_active <= 1'b0;
            else if (start_w)
                bus_active <= 1'b1;
            if (!en || frame_reset || stop_w)
                scl_low_seen <= 1'b0;
            else if (bus_active && !scl_s)
                scl_low_seen <= 1'b1;
            if (!en || frame_reset)
                bit_cnt <= 4'h0;
            else if (bus_active && scl_rise && bit_cnt != ACK_SLOT)
                bit_cnt <= bit_cnt + 4'h1;
            else if (scl_fall && bit_cnt == ACK_SLOT)
                bit_cnt <= 4'h0;
            if (bus_active && scl_rise && bit_cnt < BITS_PER_BYTE)
                shift <= rx_byte;
        end
    end

    // ------------------------------------------------------------
    // Matching, read hold and master start
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            prior_match_o <= 1'b0;
            read_pend <= 1'b0;
            read_hold <= 1'b0;
            gen_drive <= 1'b0;
        end
        else
        begin
            if (!en || prior_clear)
                prior_match_o <= 1'b0;
            else if (prior_set)
                prior_match_o <= 1'b1;
            // The clock is only stretched once the acknowledge slot has ended.
            if (!en || frame_reset || stop_w)
                read_pend <= 1'b0;
            else if (ten_read_ok)
                read_pend <= 1'b1;
            else if (scl_fall && bit_cnt == ACK_SLOT)
                read_pend <= 1'b0;
            // A release that lands on the setting edge loses, so a hold is never missed.
            if (!en || stop_w)
                read_hold <= 1'b0;
            else if (read_pend && scl_fall && bit_cnt == ACK_SLOT)
                read_hold <= 1'b1;
            else if (read_release_i)
                read_hold <= 1'b0;
            if (!en)
                gen_drive <= 1'b0;
            else if (gen_ok && sda_s)
                gen_drive <= 1'b1;
            else if (bus_active && !scl_s)
                gen_drive <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Transmit data hold
    // ------------------------------------------------------------
    // The new bit waits a full hold count after every SCL fall.
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            hold_cnt <= 4'h0;
            sda_tx <= 1'b1;
        end
        else if (!en || !tx_enable_i)
        begin
            hold_cnt <= 4'h0;
            sda_tx <= 1'b1;
        end
        else if (scl_fall)
        begin
            hold_cnt <= hold_load;
        end
        else if (hold_busy)
        begin
            hold_cnt <= hold_cnt - 4'h1;
            if (hold_cnt == 4'h1)
                sda_tx <= tx_bit_i;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            scl_oe_n_o <= 1'b1;
            sda_oe_n_o <= 1'b1;
            bus_idle_o <= 1'b0;
            start_det_o <= 1'b0;
            stop_det_o <= 1'b0;
            restart_det_o <= 1'b0;
            collision_o <= 1'b0;
            addr_match_o <= 1'b0;
            read_hold_o <= 1'b0;
        end
        else
        begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            scl_oe_n_o <= ~(en & read_hold);
            sda_oe_n_o <= ~drive_sda;
            bus_idle_o <= en & ~bus_active & ~start_w & sda_s & scl_s;
            start_det_o <= start_w;
            stop_det_o <= stop_w;
            restart_det_o <= restart_w;
            collision_o <= tx_collide | gen_collide;
            addr_match_o <= en & full_match;
            read_hold_o <= en & read_hold;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    property p_pin_data_zero;
        scl_o == 1'b0 && sda_o == 1'b0;
    endproperty
    a_pin_data_zero: assert property (p_pin_data_zero) else $error("pin data not zero");

    property p_release_when_off;
        !en |=> sda_oe_n_o && scl_oe_n_o;
    endproperty
    a_release_when_off: assert property (p_release_when_off) else $error("line driven while off");

    property p_idle_levels;
        bus_idle_o |-> $past(sda_s && scl_s && !bus_active);
    endproperty
    a_idle_levels: assert property (p_idle_levels) else $error("idle with a line low");

    property p_start_active;
        start_w |=> start_det_o && !bus_idle_o ##1 bus_active;
    endproperty
    a_start_active: assert property (p_start_active) else $error("start not flagged");

    property p_stop_needs_low;
        stop_det_o |-> $past(scl_low_seen, 1) && $past(sda_rise, 1);
    endproperty
    a_stop_needs_low: assert property (p_stop_needs_low) else $error("stop without scl low");

    property p_restart_resets;
        restart_w |=> restart_det_o && addr_st == ADDR_FIRST && bit_cnt == 4'h0;
    endproperty
    a_restart_resets: assert property (p_restart_resets) else $error("restart left state");

    property p_start_collide;
        gen_collide |=> collision_o && sda_oe_n_o;
    endproperty
    a_start_collide: assert property (p_start_collide) else $error("start collision missed");

    property p_tx_collide;
        tx_collide |=> collision_o;
    endproperty
    a_tx_collide: assert property (p_tx_collide) else $error("collision missed");

    property p_long_hold;
        en && tx_enable_i && scl_fall && long_hold_select_i
            |=> (hold_busy && $stable(sda_tx)) [*7];
    endproperty
    a_long_hold: assert property (p_long_hold) else $error("long hold cut short");

    property p_prior_stop;
        stop_w |=> !prior_match_o;
    endproperty
    a_prior_stop: assert property (p_prior_stop) else $error("prior match survived stop");

    property p_read_hold_scl;
        en && read_hold |=> !scl_oe_n_o && read_hold_o;
    endproperty
    a_read_hold_scl: assert property (p_read_hold_scl) else $error("read hold not on scl");

    property p_header_fail;
        ten_first && !hi_match |=> addr_st == ADDR_IGNORE && !addr_match_o;
    endproperty
    a_header_fail: assert property (p_header_fail) else $error("bad header accepted");

    property p_seven_match;
        first_byte && !ten_bit_mode_i && en |=> addr_match_o == $past(match7);
    endproperty
    a_seven_match: assert property (p_seven_match) else $error("7-bit match wrong");

    c_start: cover property (start_w ##[1:1000] stop_w);
    c_restart: cover property (restart_det_o);
    c_read_hold: cover property (read_hold_o);
    c_collision: cover property (collision_o);

endmodule : ibc_bus_cond

`default_nettype wire

//--- src/ibc_pkg.sv
/*
 * Shared constants and types for the two-wire bus condition front end.
 * Assumes a 25 MHz system clock; every cycle count is derived from it.
 */
package ibc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SYS_PERIOD_NS = 40;
    localparam int HOLD_LONG_NS = 300;
    localparam int HOLD_SHORT_NS = 100;
    // Least times round up to whole cycles.
    localparam int HOLD_LONG_CYC = (HOLD_LONG_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int HOLD_SHORT_CYC = (HOLD_SHORT_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam logic [3:0] HOLD_LONG_CNT = 4'(HOLD_LONG_CYC);
    localparam logic [3:0] HOLD_SHORT_CNT = 4'(HOLD_SHORT_CYC);

    // ------------------------------------------------------------
    // Byte framing and addressing
    // ------------------------------------------------------------
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] ACK_SLOT = 4'h9;
    localparam logic [4:0] TEN_BIT_HEADER = 5'h1E;
    localparam int HDR_MSB = 7;
    localparam int HDR_LSB = 3;
    localparam int HI_ADDR_MSB = 2;
    localparam int HI_ADDR_LSB = 1;
    localparam int RW_BIT = 0;

    typedef enum logic [1:0] {
        ADDR_FIRST,
        ADDR_LOW,
        ADDR_DATA,
        ADDR_IGNORE
    } ibc_addr_t;

endpackage : ibc_pkg

//--- src/ibc_sync.sv
/*
 * Two flip-flop level synchroniser, one instance per destination clock.
 * Assumes the inputs are levels that stay put for several destination cycles.
 */
`timescale 1ns/1ps
`default_nettype none

module ibc_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta;

    // The first stage feeds the second stage and nothing else.
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            meta <= '1;
            q_o <= '1;
        end
        else
        begin
            meta <= d_i;
            q_o <= meta;
        end
    end

endmodule : ibc_sync

`default_nettype wire

//--- verif/i2c_bus_condition_logic_tb.sv
/*
 * Self-checking bench for the bus condition front end.
 * Assumes the master model drives the wires and pulses are counted per clock.
 */
`timescale 1ns/1ps
`default_nettype none

module i2c_bus_condition_logic_tb;
    import ibc_pkg::*;
    logic sys_clk = 1'b0, link_clk = 1'b0;
    logic reset_n, en, mode, ten, lhs, sgr, txe, txb, rel;
    logic [7:0] adr_one, adr_two;
    logic [9:0] adr_ten;
    logic m_scl, m_sda, scl_w, sda_w, scl_o, scl_oe_n, sda_o, sda_oe_n;
    logic idle, st_o, sp_o, rs_o, col_o, am_o, prior, rhold;
    int num_errors = 0, n_tests = 0, cyc = 0;
    int n_st = 0, n_sp = 0, n_rs = 0, n_col = 0, n_am = 0;
    realtime t_fall, t_lo, t_hi, d_long;

    always #20 sys_clk = ~sys_clk;
    always #62.5 link_clk = ~link_clk;
    // Open-drain wires: any party pulling low wins over the pull-up.
    assign scl_w = ~m_scl & (scl_oe_n | scl_o);
    assign sda_w = ~m_sda & (sda_oe_n | sda_o);

    ibc_bus_cond u_dut (
        .sys_clk_i(sys_clk), .reset_n_i(reset_n), .link_clk_i(link_clk),
        .scl_pin_i(scl_w), .sda_pin_i(sda_w),
        .scl_o(scl_o), .scl_oe_n_o(scl_oe_n), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
        .serial_port_enable_i(en), .i2c_mode_sel_i(mode), .ten_bit_mode_i(ten),
        .long_hold_select_i(lhs), .slave_address_match_value_i(adr_one),
        .slave_address_match_value_two_i(adr_two), .ten_bit_address_i(adr_ten),
        .start_gen_req_i(sgr), .tx_enable_i(txe), .tx_bit_i(txb), .read_release_i(rel),
        .bus_idle_o(idle), .start_det_o(st_o), .stop_det_o(sp_o), .restart_det_o(rs_o),
        .collision_o(col_o), .addr_match_o(am_o), .prior_match_o(prior),
        .read_hold_o(rhold)
    );

    ibc_master_model u_m (
        .link_clk_i(link_clk), .scl_i(scl_w), .scl_low_o(m_scl), .sda_low_o(m_sda)
    );

    // ----------------
    // Monitors
    // ----------------
    // Pulses are counted at the falling edge, well clear of the edge that launches them.
    always @(negedge sys_clk)
    begin
        n_st += (st_o === 1'b1);
        n_sp += (sp_o === 1'b1);
        n_rs += (rs_o === 1'b1);
        n_col += (col_o === 1'b1);
        n_am += (am_o === 1'b1);
        cyc++;
        if (cyc == 30000)
        begin
            num_errors++;
            final_report();
        end
    end
    always @(negedge scl_w) t_fall = $realtime;
    always @(negedge sda_oe_n) t_lo = $realtime;
    always @(posedge sda_oe_n) t_hi = $realtime;

    // ----------------
    // Helpers
    // ----------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic settle();
        repeat (20) @(negedge sys_clk);
    endtask : settle

    // The hold counter runs after the synchroniser delay, so wait for the enable to move.
    task automatic wait_oe(input logic v);
        for (int i = 0; i < 40 && sda_oe_n !== v; i++)
            @(negedge sys_clk);
        check("sda oe wait", sda_oe_n, v);
    endtask : wait_oe

    task automatic end_test(input string name);
        check("scl data", scl_o, 0);
        check("sda data", sda_o, 0);
        $display("test %s done", name);
    endtask : end_test

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    // ----------------
    // Tests
    // ----------------
    initial
    begin
        reset_n = 1'b0;
        {en, mode, ten, lhs, sgr, txe, txb, rel} = 8'h00;
        adr_one = 8'hA4;
        adr_two = 8'h3A;
        adr_ten = 10'h2C7;
        repeat (5) @(negedge sys_clk);
        reset_n = 1'b1;
        en = 1'b1;
        mode = 1'b1;
        settle();
        check("scl oe", scl_oe_n, 1);
        check("sda oe", sda_oe_n, 1);
        check("idle", idle, 1);
        end_test("reset");
        // SDA low then high with SCL high throughout.
        u_m.sda_set(1'b0);
        u_m.sda_set(1'b1);
        settle();
        check("start", n_st, 1);
        check("stop", n_sp, 0);
        check("idle", idle, 0);
        u_m.scl_set(1'b0);
        u_m.stop_cond();
        settle();
        check("stop", n_sp, 1);
        check("idle", idle, 1);
        end_test("glitch");
        u_m.start_cond();
        u_m.send_byte(8'hA5);
        check("match one", n_am, 1);
        u_m.restart_cond();
        check("restart", n_rs, 1);
        u_m.send_byte(8'h3B);
        check("match two", n_am, 2);
        u_m.restart_cond();
        u_m.send_byte(8'h44);
        check("no match", n_am, 2);
        u_m.stop_cond();
        check("starts", n_st, 2);
        end_test("seven");
        @(negedge sys_clk) ten = 1'b1;
        u_m.start_cond();
        u_m.send_byte(8'hF4);
        u_m.send_byte(8'hC7);
        check("low match", n_am, 3);
        check("prior", prior, 1);
        u_m.restart_cond();
        u_m.send_byte(8'hF5);
        settle();
        check("read match", n_am, 4);
        check("read hold", rhold, 1);
        check("scl held", scl_oe_n, 0);
        @(negedge sys_clk) rel = 1'b1;
        @(negedge sys_clk) rel = 1'b0;
        settle();
        check("hold released", scl_oe_n, 1);
        u_m.restart_cond();
        u_m.send_byte(8'hF4);
        check("prior cleared", prior, 0);
        // A header with the wrong top address bits is ignored.
        u_m.restart_cond();
        u_m.send_byte(8'hF2);
        check("bad header", n_am, 4);
        u_m.stop_cond();
        end_test("ten");
        @(negedge sys_clk);
        ten = 1'b0;
        txe = 1'b1;
        lhs = 1'b1;
        u_m.start_cond();
        wait_oe(1'b0);
        d_long = t_lo - t_fall;
        check("long hold", d_long >= 1.0 * HOLD_LONG_NS, 1);
        @(negedge sys_clk);
        txb = 1'b1;
        lhs = 1'b0;
        u_m.send_bit(1'b0);
        wait_oe(1'b1);
        check("short hold", (t_hi - t_fall) < d_long, 1);
        check("short min", (t_hi - t_fall) >= 1.0 * HOLD_SHORT_NS, 1);
        u_m.send_bit(1'b0);
        @(negedge sys_clk) txe = 1'b0;
        u_m.stop_cond();
        check("tx collision", n_col, 1);
        end_test("transmit");
        @(negedge sys_clk) sgr = 1'b1;
        @(negedge sys_clk) sgr = 1'b0;
        @(negedge sys_clk);
        check("start drive", sda_oe_n, 0);
        settle();
        check("own start", n_st, 5);
        u_m.scl_set(1'b0);
        settle();
        check("sda released", sda_oe_n, 1);
        u_m.stop_cond();
        // Hold SDA low under a high SCL without any Start.
        u_m.scl_set(1'b0);
        u_m.sda_set(1'b0);
        u_m.scl_set(1'b1);
        @(negedge sys_clk) sgr = 1'b1;
        @(negedge sys_clk) sgr = 1'b0;
        settle();
        check("start collision", n_col, 2);
        check("no drive", sda_oe_n, 1);
        // Leaving the two-wire mode must drop the idle flag and release both lines.
        @(negedge sys_clk) mode = 1'b0;
        settle();
        check("off idle", idle, 0);
        check("off sda", sda_oe_n, 1);
        check("off scl", scl_oe_n, 1);
        mode = 1'b1;
        end_test("start generation");
        final_report();
    end

endmodule : i2c_bus_condition_logic_tb

`default_nettype wire

//--- verif/ibc_master_model.sv
/*
 * Behavioural two-wire master standing on the far side of the bus pins.
 * Assumes pull-ups on both wires and a free-running link clock.
 */
`timescale 1ns/1ps
`default_nettype none

module ibc_master_model (
    input wire logic link_clk_i,
    input wire logic scl_i,
    output logic scl_low_o,
    output logic sda_low_o
);
    // ----------------
    // Line control
    // ----------------
    initial
    begin
        scl_low_o = 1'b0;
        sda_low_o = 1'b0;
    end

    // Four link periods per level keep every level well past the two-stage sampler.
    task automatic step();
        repeat (4) @(negedge link_clk_i);
    endtask : step

    // Releasing SCL waits, bounded, for a slave that stretches the clock.
    task automatic scl_set(input logic hi);
        int n = 0;
        scl_low_o = ~hi;
        while (hi && scl_i !== 1'b1 && n < 2000)
        begin
            @(negedge link_clk_i);
            n++;
        end
        step();
    endtask : scl_set

    task automatic sda_set(input logic hi);
        sda_low_o = ~hi;
        step();
    endtask : sda_set

    // ----------------
    // Conditions and bytes
    // ----------------
    task automatic start_cond();
        sda_set(1'b0);
        scl_set(1'b0);
    endtask : start_cond

    task automatic stop_cond();
        sda_set(1'b0);
        scl_set(1'b1);
        sda_set(1'b1);
    endtask : stop_cond

    task automatic restart_cond();
        sda_set(1'b1);
        scl_set(1'b1);
        sda_set(1'b0);
        scl_set(1'b0);
    endtask : restart_cond

    task automatic send_bit(input logic b);
        sda_set(b);
        scl_set(1'b1);
        scl_set(1'b0);
    endtask : send_bit

    // The acknowledge slot is left released; this block never answers it.
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            send_bit(b[i]);
        end
        send_bit(1'b1);
    endtask : send_byte

endmodule : ibc_master_model

`default_nettype wire
